// ===== verilog/spi_eeprom.sv
// Serial EEPROM device: command decoder, array, page buffer, write cycle.
// Assumes SPI mode 0 pins sampled by sys_clk, well oversampling the link clock.
`timescale 1ns/1ns
module spi_eeprom
    import eeprom_pkg::*;
#(
    parameter int ADDR_W = eeprom_pkg::ADDR_W_SMALL,
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Serial link pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    // Serial data out with its enable
    output logic so,
    output logic so_oe
);
    import eeprom_pkg::*;

    // ------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------
    localparam logic [ADDR_BITS-1:0] AMASK = ADDR_BITS'((1 << ADDR_W) - 1);
    localparam logic [WC_CNT_W-1:0] WC_LAST = WC_CNT_W'(WRITE_CYCLES - 1);
    localparam logic [PAGE_W:0] COMMIT_END = (PAGE_W+1)'(PAGE_BYTES);

    // Keeps only the decoded address bits.
    function automatic logic [ADDR_BITS-1:0] amask(input logic [ADDR_BITS-1:0] a);
        amask = a & AMASK;
    endfunction

    // Tells whether an address lies in the block-protected range.
    function automatic logic in_block(input logic [1:0] lvl, input logic [ADDR_BITS-1:0] a);
        case (lvl)
            LVL_NONE: in_block = 1'b0;
            LVL_QUARTER: in_block = (a[ADDR_W-1:ADDR_W-2] == 2'b11);
            LVL_HALF: in_block = a[ADDR_W-1];
            default: in_block = 1'b1;
        endcase
    endfunction

    // Builds the status byte; all ones while the write cycle runs.
    function automatic logic [7:0] status_of(input state_s s);
        logic [7:0] v;
        v = '0;
        v[ST_PIN_EN] = s.pin_en;
        v[ST_LVL_HI:ST_LVL_LO] = s.level;
        v[ST_WEN] = s.wen;
        status_of = s.busy ? STATUS_BUSY_VAL : v;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    pins_s pins_raw;
    pins_s pins;

    assign pins_raw = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};

    pin_sync #(
        .W(4),
        .RST_VAL(4'h9)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(pins_raw),
        .q(pins)
    );

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] page_buf [0:PAGE_BYTES-1];
    state_s st_reg;
    state_s st_next;
    logic buf_we;
    logic [PAGE_W-1:0] buf_idx;
    logic [7:0] buf_data;
    logic commit_we;
    logic [ADDR_W-1:0] commit_addr;
    logic [PAGE_W-1:0] commit_idx;

    assign commit_idx = st_reg.commit[PAGE_W-1:0];
    assign commit_addr = {st_reg.addr[ADDR_W-1:PAGE_W], commit_idx};
    assign commit_we = st_reg.busy && (st_reg.commit < COMMIT_END) && st_reg.mask[commit_idx];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic rise;
        logic fall;
        logic hw_prot;
        logic [7:0] op;
        logic [7:0] byte_in;
        logic [ADDR_BITS-1:0] a;
        rise = 1'b0;
        fall = 1'b0;
        hw_prot = 1'b0;
        op = '0;
        byte_in = '0;
        a = '0;
        st_next = st_reg;
        buf_we = 1'b0;
        buf_idx = st_reg.addr[PAGE_W-1:0];
        buf_data = '0;
        rise = pins.sck & ~st_reg.sck_q;
        fall = ~pins.sck & st_reg.sck_q;
        hw_prot = ~pins.wp_n & st_reg.pin_en;
        byte_in = {st_reg.sh_in[6:0], pins.si};
        st_next.sck_q = pins.sck;
        st_next.cs_q = pins.cs_n;
        st_next.so_oe = ~pins.cs_n;

        // Self-timed write cycle: commit buffer, then finish.
        if (st_reg.busy)
        begin
            if (st_reg.commit < COMMIT_END)
            begin
                st_next.commit = st_reg.commit + 1'b1;
            end
            if (st_reg.wc_cnt == WC_LAST)
            begin
                st_next.busy = 1'b0;
                st_next.wen = 1'b0;
                st_next.mask = '0;
                if (st_reg.stat_pend)
                begin
                    st_next.pin_en = st_reg.stat_new[ST_PIN_EN];
                    st_next.level = st_reg.stat_new[ST_LVL_HI:ST_LVL_LO];
                    st_next.stat_pend = 1'b0;
                end
            end
            else
            begin
                st_next.wc_cnt = st_reg.wc_cnt + 1'b1;
            end
        end

        if (pins.cs_n)
        begin
            // Select high: end of frame, maybe start programming.
            if (!st_reg.cs_q)
            begin
                if (st_reg.phase == PH_WRITE && st_reg.cnt == '0 && st_reg.mask != '0)
                begin
                    st_next.busy = 1'b1;
                    st_next.wc_cnt = '0;
                    st_next.commit = '0;
                end
                else if (st_reg.phase == PH_STAT_WR && st_reg.cnt == '0 && st_reg.stat_pend)
                begin
                    st_next.busy = 1'b1;
                    st_next.wc_cnt = '0;
                    st_next.commit = COMMIT_END;
                end
                else if (!st_reg.busy)
                begin
                    st_next.mask = '0;
                    st_next.stat_pend = 1'b0;
                end
            end
            st_next.phase = PH_IDLE;
            st_next.cnt = '0;
        end
        else if (st_reg.cs_q)
        begin
            st_next.phase = PH_HEAD;
            st_next.cnt = '0;
        end
        else if (rise)
        begin
            // Rising edge: sample serial input.
            case (st_reg.phase)
                PH_HEAD:
                begin
                    st_next.sh_in = byte_in;
                    st_next.cnt = st_reg.cnt + 1'b1;
                    if (st_reg.cnt > OPC_LAST)
                    begin
                        st_next.addr = {st_reg.addr[ADDR_BITS-2:0], pins.si};
                    end
                    if (st_reg.cnt == OPC_LAST)
                    begin
                        op = byte_in & OP_MASK;
                        st_next.phase = PH_IGNORE;
                        st_next.cnt = st_reg.cnt + 1'b1;
                        if (st_reg.busy && op != OP_STATUS_READ)
                        begin
                            st_next.phase = PH_IGNORE;
                        end
                        else
                        begin
                            case (op)
                                OP_LATCH_SET: st_next.wen = 1'b1;
                                OP_LATCH_CLEAR: st_next.wen = 1'b0;
                                OP_STATUS_READ:
                                begin
                                    st_next.phase = PH_STAT_RD;
                                    st_next.sh_out = status_of(st_reg);
                                    st_next.cnt = '0;
                                end
                                OP_STATUS_WRITE:
                                begin
                                    if (st_reg.wen && !hw_prot)
                                    begin
                                        st_next.phase = PH_STAT_WR;
                                        st_next.cnt = '0;
                                    end
                                end
                                OP_READ:
                                begin
                                    st_next.phase = PH_HEAD;
                                    st_next.is_write = 1'b0;
                                end
                                OP_WRITE:
                                begin
                                    if (st_reg.wen)
                                    begin
                                        st_next.phase = PH_HEAD;
                                        st_next.is_write = 1'b1;
                                    end
                                end
                                default: st_next.phase = PH_IGNORE;
                            endcase
                        end
                    end
                    if (st_reg.cnt == ADDR_LAST)
                    begin
                        a = amask({st_reg.addr[ADDR_BITS-2:0], pins.si});
                        st_next.addr = a;
                        st_next.cnt = '0;
                        st_next.phase = st_reg.is_write ? PH_WRITE : PH_READ;
                        st_next.sh_out = mem[a[ADDR_W-1:0]];
                    end
                end
                PH_WRITE:
                begin
                    st_next.sh_in = byte_in;
                    st_next.cnt = {2'b00, st_reg.cnt[2:0] + 3'h1};
                    if (st_reg.cnt[2:0] == BYTE_LAST)
                    begin
                        if (!in_block(st_reg.level, st_reg.addr))
                        begin
                            buf_we = 1'b1;
                            buf_data = byte_in;
                            st_next.mask[st_reg.addr[PAGE_W-1:0]] = 1'b1;
                        end
                        st_next.addr = {st_reg.addr[ADDR_BITS-1:PAGE_W],
                                        st_reg.addr[PAGE_W-1:0] + 1'b1};
                    end
                end
                PH_STAT_WR:
                begin
                    st_next.sh_in = byte_in;
                    st_next.cnt = {2'b00, st_reg.cnt[2:0] + 3'h1};
                    if (st_reg.cnt[2:0] == BYTE_LAST)
                    begin
                        st_next.stat_new = byte_in;
                        st_next.stat_pend = 1'b1;
                    end
                end
                default:
                begin
                    st_next.cnt = st_reg.cnt;
                end
            endcase
        end
        else if (fall)
        begin
            // Falling edge: shift next output bit.
            case (st_reg.phase)
                PH_READ, PH_STAT_RD:
                begin
                    st_next.so = st_reg.sh_out[7];
                    st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
                    st_next.cnt = {2'b00, st_reg.cnt[2:0] + 3'h1};
                    if (st_reg.cnt[2:0] == BYTE_LAST)
                    begin
                        if (st_reg.phase == PH_READ)
                        begin
                            a = amask(st_reg.addr + 1'b1);
                            st_next.addr = a;
                            st_next.sh_out = mem[a[ADDR_W-1:0]];
                        end
                        else
                        begin
                            st_next.sh_out = status_of(st_reg);
                        end
                    end
                end
                default:
                begin
                    st_next.so = st_reg.so;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register and memories
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.cs_q <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Page buffer fill and array programming; array has no reset.
    always_ff @(posedge sys_clk)
    begin
        if (buf_we)
        begin
            page_buf[buf_idx] <= buf_data;
        end
        if (commit_we)
        begin
            mem[commit_addr] <= page_buf[commit_idx];
        end
    end

    assign so = st_reg.so;
    assign so_oe = st_reg.so_oe;

endmodule

// ===== verilog/eeprom_pkg.sv
// Shared constants and types for the serial EEPROM device model.
// Assumes a single system clock; all pins arrive asynchronously.
package eeprom_pkg;

    // ------------------------------------------------------------
    // Command opcodes (bit three is a don't-care, removed by mask)
    // ------------------------------------------------------------
    localparam logic [7:0] OP_MASK = 8'hF7;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // ------------------------------------------------------------
    // Frame layout and geometry
    // ------------------------------------------------------------
    localparam logic [4:0] OPC_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_W = 5;
    localparam int ADDR_BITS = 16;
    localparam int ADDR_W_SMALL = 10;
    localparam int ADDR_W_LARGE = 11;

    // ------------------------------------------------------------
    // Status byte layout
    // ------------------------------------------------------------
    localparam int ST_WEN = 1;
    localparam int ST_LVL_LO = 2;
    localparam int ST_LVL_HI = 3;
    localparam int ST_PIN_EN = 7;
    localparam logic [7:0] STATUS_BUSY_VAL = 8'hFF;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_QUARTER = 2'h1;
    localparam logic [1:0] LVL_HALF = 2'h2;

    // ------------------------------------------------------------
    // Self-timed write cycle, longest time rounded down
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int T_WC_MS = 5;
    localparam int WRITE_CYCLES_DEF = T_WC_MS * (CLK_HZ / 1000);
    localparam int WC_CNT_W = 20;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_HEAD = 3'b001,
        PH_READ = 3'b010,
        PH_WRITE = 3'b011,
        PH_STAT_RD = 3'b100,
        PH_STAT_WR = 3'b101,
        PH_IGNORE = 3'b110
    } phase_e;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
    } pins_s;

    typedef struct packed {
        phase_e phase;
        logic sck_q;
        logic cs_q;
        logic [4:0] cnt;
        logic is_write;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic [ADDR_BITS-1:0] addr;
        logic wen;
        logic [1:0] level;
        logic pin_en;
        logic busy;
        logic [WC_CNT_W-1:0] wc_cnt;
        logic [PAGE_W:0] commit;
        logic [PAGE_BYTES-1:0] mask;
        logic stat_pend;
        logic [7:0] stat_new;
        logic so;
        logic so_oe;
    } state_s;

endpackage

// ===== verilog/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the reader uses only the second stage.
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pins and synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // Metastability stage then output stage.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

// ===== verification/spi_eeprom_chk.sv
// Concurrent checks on the serial EEPROM device pins.
// Assumes link pins change away from the rising sys_clk edge.
`timescale 1ns/1ns
module spi_eeprom_chk #(
    parameter int ADDR_W = 10,
    parameter int WRITE_CYCLES = 625000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_n,
    // Serial data out
    input wire logic so,
    input wire logic so_oe
);
    // ----------
    // Helper counters
    // ----------
    logic [3:0] low_cnt_reg;
    logic [3:0] high_cnt_reg;
    logic [3:0] slo_cnt_reg;
    logic [5:0] rise_cnt_reg;
    logic sck_q_reg;

    // Counts select low and high cycles, clock low cycles and clock rises in a frame.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            low_cnt_reg <= 4'h0;
            high_cnt_reg <= 4'h0;
            slo_cnt_reg <= 4'h0;
            rise_cnt_reg <= 6'h00;
            sck_q_reg <= 1'b0;
        end
        else
        begin
            low_cnt_reg <= cs_n ? 4'h0 : low_cnt_reg + {3'h0, low_cnt_reg != 4'hF};
            high_cnt_reg <= cs_n ? high_cnt_reg + {3'h0, high_cnt_reg != 4'hF} : 4'h0;
            slo_cnt_reg <= sck ? 4'h0 : slo_cnt_reg + {3'h0, slo_cnt_reg != 4'hF};
            rise_cnt_reg <= cs_n ? 6'h00 :
                rise_cnt_reg + {5'h00, sck && !sck_q_reg && rise_cnt_reg != 6'h3F};
            sck_q_reg <= sck;
        end
    end

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    AST_OE_OFF: assert property (cs_n [*4] |-> !so_oe)
        else $error("data out driven while deselected");
    AST_OE_ON: assert property (!cs_n [*5] |-> so_oe)
        else $error("data out not driven while selected");
    AST_OE_RISE_LAT: assert property ($rose(so_oe) |-> low_cnt_reg inside {[2:4]})
        else $error("data out enable rose at wrong time");
    AST_OE_FALL_LAT: assert property ($fell(so_oe) |-> high_cnt_reg inside {[2:4]})
        else $error("data out enable fell at wrong time");
    AST_SO_HOLD: assert property ((sck && !cs_n) [*6] |-> $stable(so))
        else $error("data out moved while clock high");
    AST_SO_AFTER_FALL: assert property (($changed(so) && low_cnt_reg > 4'h6) |->
        (!sck && slo_cnt_reg inside {[2:6]}))
        else $error("data out moved away from a clock fall");
    AST_SO_QUIET_HEAD: assert property (($changed(so) && low_cnt_reg > 4'h6) |->
        rise_cnt_reg >= 6'h08)
        else $error("data out moved during the opcode");
    AST_SO_LOW_STABLE: assert property ((!sck && !cs_n) [*8] |-> $stable(so))
        else $error("data out moved late in clock low time");

    COV_LONG_FRAME: cover property (so_oe && rise_cnt_reg == 6'h20);
    COV_DESELECT: cover property ($fell(so_oe));
    COV_SHIFT: cover property ($changed(so) && low_cnt_reg > 4'h6);
endmodule

bind spi_eeprom spi_eeprom_chk #(
    .ADDR_W(ADDR_W),
    .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sck(sck),
    .si(si),
    .wp_n(wp_n),
    .so(so),
    .so_oe(so_oe)
);

// ===== verification/spi_host_model.sv
// Mode 0 serial host that drives the EEPROM link pins.
// Assumes a free running sys_clk; pins change on its falling edge.
`timescale 1ns/1ns
module spi_host_model (
    // Clock
    input wire logic sys_clk,
    // Pins towards the device
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    // A floating data-out wire is seen as the inverse of the last value.
    logic so_line;
    assign so_line = so_oe ? so : ~so;

    // Idle pins: deselected, link clock standing low.
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // Opens a frame with a falling select edge.
    task automatic begin_f();
        @(negedge sys_clk);
        cs_n = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask

    // Moves one byte each way, MSB first; data is set while the clock is low.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        for (i = 7; i >= 0; i--)
        begin
            si = tx[i];
            repeat (8) @(negedge sys_clk);
            sck = 1'b1;
            rx = {rx[6:0], so_line};
            repeat (8) @(negedge sys_clk);
            sck = 1'b0;
        end
    endtask

    // Raises select in the clock low time right after the last bit.
    task automatic end_f();
        repeat (4) @(negedge sys_clk);
        cs_n = 1'b1;
        si = ~si;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule

// ===== verification/spi_eeprom_read_write_protect_test.sv
// Self-checking bench for the serial EEPROM device.
// Assumes the host model performs every frame on the link pins.
`timescale 1ns/1ns
module spi_eeprom_read_write_protect_test;
    import eeprom_pkg::*;

    // ----------
    // Signals and instances
    // ----------
    logic sys_clk;
    logic rst_n;
    logic wp_n;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    int errors;
    int n_checks;
    int o;
    logic [7:0] rx;
    logic [7:0] st;
    logic [7:0] got [0:31];

    spi_eeprom #(.ADDR_W(10), .WRITE_CYCLES(1500)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));
    spi_host_model u_host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si),
        .so(so), .so_oe(so_oe));

    // Free running system clock.
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------
    // Tasks
    // ----------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Sends an opcode, or a status write with its byte, in one frame.
    task automatic cmd(input logic [7:0] op, input logic [7:0] v, input bit two);
        u_host.begin_f();
        u_host.xfer(op, rx);
        if (two)
            u_host.xfer(v, rx);
        u_host.end_f();
    endtask

    task automatic status(output logic [7:0] s);
        u_host.begin_f();
        u_host.xfer(OP_STATUS_READ, rx);
        u_host.xfer(8'h00, s);
        u_host.end_f();
    endtask

    // Polls until the write cycle ends; running out of tries ends the run.
    task automatic poll();
        int n;
        st = 8'hFF;
        for (n = 0; n < 40 && st[0] !== 1'b0; n++)
            status(st);
        if (st[0] !== 1'b0)
        begin
            errors++;
            wrap_up();
        end
    endtask

    // Writes n bytes base, base+1, ... from addr; opcode bit three set.
    task automatic wr(input logic [15:0] addr, input int n, input logic [7:0] base);
        int k;
        u_host.begin_f();
        u_host.xfer(OP_WRITE | 8'h08, rx);
        u_host.xfer(addr[15:8], rx);
        u_host.xfer(addr[7:0], rx);
        for (k = 0; k < n; k++)
            u_host.xfer(base + 8'(k), rx);
        u_host.end_f();
    endtask

    // Reads n bytes from addr in one frame while toggling the ignored input.
    task automatic rd(input logic [15:0] addr, input int n);
        int k;
        u_host.begin_f();
        u_host.xfer(OP_READ | 8'h08, rx);
        u_host.xfer(addr[15:8], rx);
        u_host.xfer(addr[7:0], rx);
        for (k = 0; k < n; k++)
            u_host.xfer(~addr[7:0] ^ 8'(k), got[k]);
        u_host.end_f();
    endtask

    // ----------
    // Main sequence
    // ----------
    initial
    begin
        errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        wp_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        status(st);
        check(st, 8'h00);
        // Latch set and clear with the ignored opcode bit both ways.
        cmd(8'h0E, 8'h00, 0);
        status(st);
        check(st, 8'h02);
        cmd(OP_LATCH_CLEAR, 8'h00, 0);
        status(st);
        check(st, 8'h00);
        cmd(OP_LATCH_SET, 8'h00, 0);
        // Overlong page write with upper address bits set.
        wr(16'hFC5E, 34, 8'h30);
        status(st);
        check(st, 8'hFF);
        poll();
        check(st, 8'h00);
        rd(16'h0040, 32);
        for (o = 0; o < 32; o++)
            check(got[o], 8'h32 + 8'(o));
        // Write without the latch is dropped.
        wr(16'h0040, 1, 8'hEE);
        status(st);
        check(st, 8'h00);
        rd(16'h0040, 1);
        check(got[0], 8'h32);
        // Commands other than status read are ignored while busy.
        cmd(OP_LATCH_SET, 8'h00, 0);
        wr(16'h03FE, 2, 8'hA0);
        rd(16'h0040, 1);
        check({7'h00, got[0] === 8'h32}, 8'h00);
        status(st);
        check(st, 8'hFF);
        poll();
        cmd(OP_LATCH_SET, 8'h00, 0);
        wr(16'h0000, 2, 8'hC0);
        poll();
        rd(16'h03FE, 4);
        check(got[0], 8'hA0);
        check(got[1], 8'hA1);
        check(got[2], 8'hC0);
        check(got[3], 8'hC1);
        // Quarter block protection and pin enable.
        cmd(OP_LATCH_SET, 8'h00, 0);
        cmd(OP_STATUS_WRITE, 8'h84, 1);
        poll();
        check(st, 8'h84);
        cmd(OP_LATCH_SET, 8'h00, 0);
        wr(16'h03FF, 1, 8'h55);
        poll();
        cmd(OP_LATCH_SET, 8'h00, 0);
        wr(16'h0001, 1, 8'h66);
        poll();
        rd(16'h03FF, 3);
        check(got[0], 8'hA1);
        check(got[1], 8'hC0);
        check(got[2], 8'h66);
        // Hardware protection holds the status register.
        wp_n = 1'b0;
        cmd(OP_LATCH_SET, 8'h00, 0);
        cmd(8'h09, 8'h00, 1);
        status(st);
        check(st, 8'h86);
        wp_n = 1'b1;
        cmd(OP_STATUS_WRITE, 8'h00, 1);
        poll();
        check(st, 8'h00);
        cmd(OP_STATUS_WRITE, 8'h04, 1);
        status(st);
        check(st, 8'h00);
        // An opcode with a nonzero upper nibble does nothing.
        cmd(8'h16, 8'h00, 0);
        status(st);
        check(st, 8'h00);
        // Half protection: top half refused, bottom half written.
        cmd(OP_LATCH_SET, 8'h00, 0);
        cmd(OP_STATUS_WRITE, 8'h08, 1);
        poll();
        check(st, 8'h08);
        cmd(OP_LATCH_SET, 8'h00, 0);
        wr(16'h03FE, 1, 8'h11);
        poll();
        cmd(OP_LATCH_SET, 8'h00, 0);
        wr(16'h0001, 1, 8'h22);
        poll();
        rd(16'h03FE, 4);
        check(got[0], 8'hA0);
        check(got[1], 8'hA1);
        check(got[2], 8'hC0);
        check(got[3], 8'h22);
        // Whole-array protection refuses every address.
        cmd(OP_LATCH_SET, 8'h00, 0);
        cmd(OP_STATUS_WRITE, 8'h0C, 1);
        poll();
        check(st, 8'h0C);
        cmd(OP_LATCH_SET, 8'h00, 0);
        wr(16'h0000, 1, 8'h99);
        poll();
        rd(16'h0000, 1);
        check(got[0], 8'hC0);
        wrap_up();
    end
endmodule
